//--- logic/smu_pkg.sv
// Purpose: Shared constants and types for the stack math unit
// Assumes: One clock, core stack registers outside this block
// Notes: Notes on behaviour list below
package smu_pkg;
    localparam int            WORD_W   = 16;       // Stack word width
    localparam int            DW_W     = 32;       // Double word width
    localparam int            ACC_W    = 48;       // Accumulator width
    localparam int            SHCNT_W  = 5;        // Shift count width
    localparam int            LO_POS   = 0;        // Low word position
    localparam int            HI_POS   = 16;       // High word position
    localparam int            EXT_POS  = 32;       // Extension word position
    localparam logic [47:0]   ROUND_ADD = 48'h000000008000; // Rounding addend
    localparam logic [47:0]   ACC_RST  = 48'h000000000000; // Accumulator reset value
    localparam logic [1:0]    MUL_HOLD = 2'h2;     // Blocked clocks after multiply
    localparam logic [1:0]    RD_HOLD  = 2'h1;     // Blocked clocks after high or low read

    // Requests from the core
    typedef enum logic [3:0] {
        OP_NOP, OP_MULU, OP_MULS, OP_MACU, OP_MACS, OP_SHL, OP_SHR, OP_NORM,
        OP_RDHI, OP_RDLO, OP_RDEXT, OP_LDHI, OP_LDLO, OP_LDEXT
    } op_t;

    // Accumulate operand sources
    typedef enum logic [1:0] {SRC_STACK, SRC_PSTK_MEM, SRC_BUS_MEM} src_t;

    typedef struct packed {
        op_t  op;                 // Requested operation
        src_t src;                // Operand source for accumulate
    } req_t;

    // Stack effect returned to the core
    typedef struct packed {
        logic              tos_we;    // Write TOS
        logic              nos_we;    // Write NOS
        logic              push;      // Push push_data onto parameter stack
        logic              pop;       // Pop parameter stack
        logic [15:0]       tos;       // New TOS
        logic [15:0]       nos;       // New NOS
        logic [15:0]       push_data; // Word pushed to stack memory
    } stk_t;
endpackage : smu_pkg

//--- logic/lz_normaliser.sv
// Purpose: Leading zero count and left normalisation of one word
// Assumes: Purely combinational, width a parameter
// Notes: All-zero input gives count W and zero result
`timescale 1ns/100ps
module lz_normaliser #(
    parameter int W  = 32,
    parameter int CW = $clog2(W + 1)
) (
    input  wire logic [W-1:0]  val,
    output logic      [CW-1:0] count,
    output logic      [W-1:0]  shifted
);
    logic found;   // First one seen

    // Scan from the top for the first set bit
    always_comb begin
        count = '0;
        found = 1'b0;
        for (int i = W - 1; i >= 0; i--) begin
            if (!found) begin
                if (val[i]) begin
                    found = 1'b1;
                end else begin
                    count = count + CW'(1);
                end
            end
        end
    end

    // Logical left shift by the count
    assign shifted = val << count;
endmodule : lz_normaliser

//--- logic/stack_math_unit.sv
// Purpose: Multiplier, accumulator, barrel shifter and normaliser beside the stack core
// Assumes: Requests and stack words come from core logic on MCLK
// Notes: Stack effects appear one clock after the request
`timescale 1ns/100ps
module stack_math_unit (
    input  wire logic          MCLK,
    input  wire logic          RST,
    input  wire smu_pkg::req_t REQ,
    input  wire logic          ROUND_EN,
    input  wire logic [15:0]   TOS_IN,
    input  wire logic [15:0]   NOS_IN,
    input  wire logic [15:0]   PSTK_IN,
    input  wire logic [15:0]   MEM_IN,
    input  wire logic [15:0]   BUS_IN,
    output smu_pkg::stk_t      STK,
    output logic               INT_BLOCK
);
    logic [47:0]        acc_r;     // Extension, high, low words
    logic [47:0]        acc_nxt;   // Next accumulator
    smu_pkg::stk_t      stk_r;     // Registered stack effect
    smu_pkg::stk_t      stk_nxt;   // Next stack effect
    logic [1:0]         hold_r;    // Remaining blocked clocks
    logic [1:0]         hold_nxt;  // Next hold count
    logic [1:0]         hold_dec;  // Hold count after one clock

    // Request decode
    wire smu_pkg::op_t  op       = REQ.op;
    wire                is_mul   = (op == smu_pkg::OP_MULU) || (op == smu_pkg::OP_MULS);
    wire                is_mac   = (op == smu_pkg::OP_MACU) || (op == smu_pkg::OP_MACS);
    wire                is_sgn   = (op == smu_pkg::OP_MULS) || (op == smu_pkg::OP_MACS);
    wire                is_rdhl  = (op == smu_pkg::OP_RDHI) || (op == smu_pkg::OP_RDLO);

    // Accumulate operand source; plain multiply always uses the stack
    wire smu_pkg::src_t use_src  = is_mac ? REQ.src : smu_pkg::SRC_STACK;
    wire [15:0]         opa      = (use_src == smu_pkg::SRC_STACK)    ? TOS_IN :
                                   (use_src == smu_pkg::SRC_PSTK_MEM) ? PSTK_IN : BUS_IN;
    wire [15:0]         opb      = (use_src == smu_pkg::SRC_STACK) ? NOS_IN : MEM_IN;

    // One-cycle 16x16 product, sign chosen by request
    wire [16:0]         opa_x    = {is_sgn & opa[15], opa};
    wire [16:0]         opb_x    = {is_sgn & opb[15], opb};
    wire [33:0]         prod_x   = 34'($signed(opa_x) * $signed(opb_x));
    wire [47:0]         prod48   = {{16{is_sgn & prod_x[31]}}, prod_x[31:0]};

    // Rounding add in the same cycle, sign mode irrelevant
    wire [47:0]         rnd48    = ROUND_EN ? smu_pkg::ROUND_ADD : '0;
    wire [47:0]         mul48    = prod48 + rnd48;
    wire [47:0]         mac48    = acc_r + mul48;

    // Double word operand, TOS on top
    wire [31:0]         dword    = {TOS_IN, NOS_IN};
    wire [4:0]          shcnt    = acc_r[smu_pkg::EXT_POS +: smu_pkg::SHCNT_W];
    wire [31:0]         shl_val  = dword << shcnt;
    wire [31:0]         shr_val  = dword >> shcnt;
    wire [5:0]          lz_cnt;    // Leading zero count
    wire [31:0]         lz_val;    // Normalised word

    // Normaliser
    lz_normaliser #(
        .W  (smu_pkg::DW_W),
        .CW (6)
    ) u_norm (
        .val     (dword),
        .count   (lz_cnt),
        .shifted (lz_val)
    );

    // Result words as seen by reads
    wire [15:0]         lo_w     = acc_r[smu_pkg::LO_POS +: smu_pkg::WORD_W];
    wire [15:0]         hi_w     = acc_r[smu_pkg::HI_POS +: smu_pkg::WORD_W];
    wire [15:0]         ext_w    = acc_r[smu_pkg::EXT_POS +: smu_pkg::WORD_W];

    // Accumulator next value
    always_comb begin
        acc_nxt = acc_r;
        case (op)
            smu_pkg::OP_MULU,
            smu_pkg::OP_MULS: begin
                acc_nxt = mul48;
            end
            smu_pkg::OP_MACU,
            smu_pkg::OP_MACS: begin
                acc_nxt = mac48;
            end
            smu_pkg::OP_SHL: begin
                acc_nxt[31:0] = shl_val;
            end
            smu_pkg::OP_SHR: begin
                acc_nxt[31:0] = shr_val;
            end
            smu_pkg::OP_NORM: begin
                acc_nxt = {10'h000, lz_cnt, lz_val};
            end
            smu_pkg::OP_LDHI: begin
                acc_nxt[smu_pkg::HI_POS +: smu_pkg::WORD_W] = TOS_IN;
            end
            smu_pkg::OP_LDLO: begin
                acc_nxt[smu_pkg::LO_POS +: smu_pkg::WORD_W] = TOS_IN;
            end
            smu_pkg::OP_LDEXT: begin
                acc_nxt[smu_pkg::EXT_POS +: smu_pkg::WORD_W] = TOS_IN;
            end
            default: begin
                acc_nxt = acc_r;
            end
        endcase
    end

    // Stack effect for reads and loads
    always_comb begin
        stk_nxt = '0;
        case (op)
            smu_pkg::OP_RDHI,
            smu_pkg::OP_RDLO: begin
                stk_nxt.tos_we = 1'b1;
                stk_nxt.nos_we = 1'b1;
                stk_nxt.tos    = (op == smu_pkg::OP_RDHI) ? hi_w : lo_w;
                stk_nxt.nos    = TOS_IN;
            end
            smu_pkg::OP_RDEXT: begin
                stk_nxt.tos_we    = 1'b1;
                stk_nxt.nos_we    = 1'b1;
                stk_nxt.push      = 1'b1;
                stk_nxt.tos       = ext_w;
                stk_nxt.nos       = TOS_IN;
                stk_nxt.push_data = NOS_IN;
            end
            smu_pkg::OP_LDHI,
            smu_pkg::OP_LDLO,
            smu_pkg::OP_LDEXT: begin
                stk_nxt.tos_we = 1'b1;
                stk_nxt.nos_we = 1'b1;
                stk_nxt.pop    = 1'b1;
                stk_nxt.tos    = NOS_IN;
                stk_nxt.nos    = PSTK_IN;
            end
            default: begin
                stk_nxt = '0;
            end
        endcase
    end

    // Interrupt hold window; accumulate never starts one
    assign hold_dec  = (hold_r != 2'h0) ? hold_r - 2'h1 : 2'h0;
    assign hold_nxt  = is_mul ? smu_pkg::MUL_HOLD :
                       (is_rdhl && (hold_dec < smu_pkg::RD_HOLD)) ? smu_pkg::RD_HOLD : hold_dec;
    assign INT_BLOCK = is_mul || is_rdhl || (hold_r != 2'h0);

    // State registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            acc_r  <= smu_pkg::ACC_RST;
            stk_r  <= '0;
            hold_r <= 2'h0;
        end else begin
            acc_r  <= acc_nxt;
            stk_r  <= stk_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign STK = stk_r;

    // Checks
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    AST_MUL_UNSIGNED: assert property (
        op == smu_pkg::OP_MULU && !ROUND_EN |=>
        acc_r[31:0] == 32'($past(TOS_IN)) * 32'($past(NOS_IN)))
        else $error("unsigned product wrong");

    AST_MUL_SIGNED: assert property (
        op == smu_pkg::OP_MULS && !ROUND_EN |=>
        $signed(acc_r[31:0]) == 32'($signed($past(TOS_IN)) * $signed($past(NOS_IN))))
        else $error("signed product wrong");

    AST_MUL_NO_POP: assert property (
        is_mul |=> !STK.pop && !STK.tos_we && !STK.nos_we)
        else $error("multiply touched the stack");

    AST_ROUND: assert property (
        op == smu_pkg::OP_MULU && ROUND_EN |=>
        acc_r[31:0] == 32'($past(TOS_IN)) * 32'($past(NOS_IN)) + 32'h00008000)
        else $error("rounding not applied");

    AST_READ_HI: assert property (
        op == smu_pkg::OP_RDHI |=> STK.tos_we && STK.tos == $past(hi_w)
        && STK.nos == $past(TOS_IN) && !STK.push && !STK.pop)
        else $error("high read stack effect wrong");

    AST_READ_EXT: assert property (
        op == smu_pkg::OP_RDEXT |=> STK.push && STK.push_data == $past(NOS_IN)
        && STK.tos == $past(ext_w))
        else $error("extension read did not push");

    AST_LOAD_LO: assert property (
        op == smu_pkg::OP_LDLO |=> STK.pop && STK.tos == $past(NOS_IN)
        && STK.nos == $past(PSTK_IN) && acc_r[15:0] == $past(TOS_IN))
        else $error("load effect wrong");

    AST_MUL_BLOCK: assert property (
        is_mul |-> INT_BLOCK [*3])
        else $error("multiply window not blocked");

    AST_MAC_FREE: assert property (
        is_mac && hold_r == 2'h0 |-> !INT_BLOCK)
        else $error("accumulate blocked interrupts");

    AST_MAC_ACC: assert property (
        op == smu_pkg::OP_MACU && REQ.src == smu_pkg::SRC_BUS_MEM && !ROUND_EN |=>
        acc_r == $past(acc_r) + 48'($past(BUS_IN)) * 48'($past(MEM_IN)))
        else $error("accumulate sum wrong");

    AST_SHIFT_L: assert property (
        op == smu_pkg::OP_SHL |=> acc_r[31:0] == ($past(dword) << $past(shcnt)))
        else $error("left shift wrong");

    AST_NORM: assert property (
        op == smu_pkg::OP_NORM && dword != 32'h00000000 |=> acc_r[31]
        && (acc_r[31:0] >> acc_r[37:32]) == $past(dword))
        else $error("normalise wrong");

    // Low read returns the low word and drops NOS
    AST_READ_LO: assert property (
        op == smu_pkg::OP_RDLO |=> STK.tos_we && STK.nos_we && STK.tos == $past(lo_w)
        && STK.nos == $past(TOS_IN) && !STK.push && !STK.pop)
        else $error("low read stack effect wrong");

    // High load pops the stack and fills the middle word
    AST_LOAD_HI: assert property (
        op == smu_pkg::OP_LDHI |=> STK.pop && STK.tos == $past(NOS_IN)
        && STK.nos == $past(PSTK_IN) && acc_r[31:16] == $past(TOS_IN))
        else $error("high load effect wrong");

    // Extension load pops the stack and fills the top word
    AST_LOAD_EXT: assert property (
        op == smu_pkg::OP_LDEXT |=> STK.pop && STK.tos == $past(NOS_IN)
        && acc_r[47:32] == $past(TOS_IN))
        else $error("extension load effect wrong");

    // Right shift result, count word left alone
    AST_SHIFT_R: assert property (
        op == smu_pkg::OP_SHR |=> acc_r[31:0] == ($past(dword) >> $past(shcnt))
        && acc_r[47:32] == $past(acc_r[47:32]))
        else $error("right shift wrong");

    // Left shift keeps the count word
    AST_SHIFT_L_EXT: assert property (
        op == smu_pkg::OP_SHL |=> acc_r[47:32] == $past(acc_r[47:32]))
        else $error("left shift touched the count");

    // High or low read blocks its own cycle and one more
    AST_RD_BLOCK: assert property (
        is_rdhl |-> INT_BLOCK [*2])
        else $error("read window not blocked");

    // Multiply window ends after two further clocks
    AST_MUL_RELEASE: assert property (
        is_mul ##1 (!is_mul && !is_rdhl) ##1 (!is_mul && !is_rdhl) ##1 (!is_mul && !is_rdhl)
        |-> !INT_BLOCK)
        else $error("multiply window too long");

    // No window and no blocking request means interrupts free
    AST_HOLD_IDLE: assert property (
        hold_r == 2'h0 && !is_mul && !is_rdhl |-> !INT_BLOCK)
        else $error("interrupts blocked while idle");

    // Extension read never blocks interrupts by itself
    AST_EXT_RD_FREE: assert property (
        op == smu_pkg::OP_RDEXT && hold_r == 2'h0 |-> !INT_BLOCK)
        else $error("extension read blocked interrupts");

    // Normalising zero gives full count and zero word
    AST_NORM_ZERO: assert property (
        op == smu_pkg::OP_NORM && dword == 32'h00000000 |=> acc_r[31:0] == 32'h00000000
        && acc_r[47:32] == 16'h0020)
        else $error("normalise of zero wrong");

    // Unsigned multiply clears the extension word
    AST_MUL_EXT: assert property (
        op == smu_pkg::OP_MULU && !ROUND_EN |=> acc_r[47:32] == 16'h0000)
        else $error("unsigned multiply extension wrong");

    // Signed rounding adds the same half-word constant
    AST_ROUND_SIGNED: assert property (
        op == smu_pkg::OP_MULS && ROUND_EN |=>
        acc_r[31:0] == 32'($signed($past(TOS_IN)) * $signed($past(NOS_IN))) + 32'h00008000)
        else $error("signed rounding not applied");

    // Signed accumulate from the stack registers
    AST_MAC_SIGNED: assert property (
        op == smu_pkg::OP_MACS && REQ.src == smu_pkg::SRC_STACK && !ROUND_EN |=>
        acc_r == $past(acc_r) + 48'($signed($past(TOS_IN)) * $signed($past(NOS_IN))))
        else $error("signed accumulate wrong");

    // Accumulate from parameter stack and memory
    AST_MAC_PSTK: assert property (
        op == smu_pkg::OP_MACU && REQ.src == smu_pkg::SRC_PSTK_MEM && !ROUND_EN |=>
        acc_r == $past(acc_r) + 48'($past(PSTK_IN)) * 48'($past(MEM_IN)))
        else $error("stack memory accumulate wrong");

    // Accumulate leaves the stack untouched
    AST_MAC_NO_POP: assert property (
        is_mac |=> !STK.pop && !STK.push && !STK.tos_we && !STK.nos_we)
        else $error("accumulate touched the stack");

    // Idle cycle returns no stack effect
    AST_STK_IDLE: assert property (
        op == smu_pkg::OP_NOP |=> !STK.pop && !STK.push && !STK.tos_we && !STK.nos_we)
        else $error("idle cycle touched the stack");

    CV_MUL_READ: cover property (is_mul ##1 op == smu_pkg::OP_RDLO ##2 op == smu_pkg::OP_RDHI);
    CV_MAC_PSTK: cover property (op == smu_pkg::OP_MACS && REQ.src == smu_pkg::SRC_PSTK_MEM);
    CV_NORM:     cover property (op == smu_pkg::OP_NORM ##1 op == smu_pkg::OP_RDEXT);
endmodule : stack_math_unit

//--- test/core_stack_model.sv
// Purpose: Core side model holding top, next and parameter stack words
// Assumes: Stack effects arrive from the unit as one-cycle strobes
// Notes: Preset port lets the bench load the stack directly
`timescale 1ns/100ps
module core_stack_model (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire smu_pkg::stk_t stk,      // Stack effect from the unit
    input  wire logic          ld,       // Preset strobe
    input  wire logic [47:0]   ld_val,   // Preset {top, next, stack}
    output logic      [15:0]   tos_r,    // Top of stack
    output logic      [15:0]   nos_r,    // Next of stack
    output logic      [15:0]   pstk_r    // Top cell of stack memory
);
    // Presets first, otherwise apply the returned effect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {tos_r, nos_r, pstk_r} <= 48'h0;
        end else if (ld) begin
            {tos_r, nos_r, pstk_r} <= ld_val;
        end else begin
            if (stk.tos_we) tos_r <= stk.tos;
            if (stk.nos_we) nos_r <= stk.nos;
            if (stk.push) pstk_r <= stk.push_data;
            else if (stk.pop) pstk_r <= ~pstk_r; // Popped cell shows a fresh word
        end
    end
endmodule : core_stack_model

//--- test/stack_math_unit_tb.sv
// Purpose: Self-checking bench for the stack math unit
// Assumes: Results are read back through the read requests
// Notes: Rows chain, the accumulator and shift count carry over
`timescale 1ns/100ps
module stack_math_unit_tb;
    typedef struct packed {
        smu_pkg::op_t  op;
        smu_pkg::src_t src;
        logic          rnd;
        logic [15:0]   t, n, h, l, x;
    } row_t;
    logic          mclk = 1'b0;
    logic          rst  = 1'b1;
    smu_pkg::req_t req  = '0;
    logic          rnd  = 1'b0;
    logic          ld_s = 1'b0;
    logic [47:0]   ld_v = 48'h0;
    logic [15:0]   tos_w, nos_w, pstk_w;
    smu_pkg::stk_t stk;
    logic          int_blk;
    int            failures = 0;
    int            samples_checked = 0;
    smu_pkg::op_t  lds [3] = '{smu_pkg::OP_LDLO, smu_pkg::OP_LDHI, smu_pkg::OP_LDEXT};
    smu_pkg::op_t  rds [3] = '{smu_pkg::OP_RDLO, smu_pkg::OP_RDHI, smu_pkg::OP_RDEXT};
    row_t rows [17] = '{
        '{smu_pkg::OP_MULU, smu_pkg::SRC_STACK, 1'b0, 16'h0003, 16'h0005, 16'h0000, 16'h000F, 16'h0000},
        '{smu_pkg::OP_MULU, smu_pkg::SRC_STACK, 1'b0, 16'hFFFF, 16'hFFFF, 16'hFFFE, 16'h0001, 16'h0000},
        '{smu_pkg::OP_MULS, smu_pkg::SRC_STACK, 1'b0, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0001, 16'h0000},
        '{smu_pkg::OP_MULS, smu_pkg::SRC_STACK, 1'b0, 16'hFFFF, 16'h0002, 16'hFFFF, 16'hFFFE, 16'hFFFF},
        '{smu_pkg::OP_MULU, smu_pkg::SRC_STACK, 1'b1, 16'h0003, 16'h0005, 16'h0000, 16'h800F, 16'h0000},
        '{smu_pkg::OP_MULS, smu_pkg::SRC_STACK, 1'b1, 16'h0100, 16'h0180, 16'h0002, 16'h0000, 16'h0000},
        '{smu_pkg::OP_MACU, smu_pkg::SRC_STACK, 1'b0, 16'h0002, 16'h0003, 16'h0002, 16'h0006, 16'h0000},
        '{smu_pkg::OP_MACS, smu_pkg::SRC_STACK, 1'b0, 16'hFFFF, 16'h0001, 16'h0002, 16'h0005, 16'h0000},
        '{smu_pkg::OP_MACU, smu_pkg::SRC_PSTK_MEM, 1'b0, 16'h0000, 16'h0000, 16'h0002, 16'h0045, 16'h0000},
        '{smu_pkg::OP_MACU, smu_pkg::SRC_BUS_MEM, 1'b0, 16'h0000, 16'h0000, 16'h0002, 16'h0445, 16'h0000},
        '{smu_pkg::OP_MACU, smu_pkg::SRC_STACK, 1'b0, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0446, 16'h0001},
        '{smu_pkg::OP_SHL, smu_pkg::SRC_STACK, 1'b0, 16'h8001, 16'h8000, 16'h0003, 16'h0000, 16'h0001},
        '{smu_pkg::OP_SHR, smu_pkg::SRC_STACK, 1'b0, 16'h8001, 16'h8000, 16'h4000, 16'hC000, 16'h0001},
        '{smu_pkg::OP_NORM, smu_pkg::SRC_STACK, 1'b0, 16'h0000, 16'h0001, 16'h8000, 16'h0000, 16'h001F},
        '{smu_pkg::OP_SHL, smu_pkg::SRC_STACK, 1'b0, 16'h0000, 16'h0003, 16'h8000, 16'h0000, 16'h001F},
        '{smu_pkg::OP_NORM, smu_pkg::SRC_STACK, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020},
        '{smu_pkg::OP_SHR, smu_pkg::SRC_STACK, 1'b0, 16'h1234, 16'h5678, 16'h1234, 16'h5678, 16'h0020}};

    // Free-running processor clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    stack_math_unit stack_math_unit_i (.MCLK(mclk), .RST(rst), .REQ(req), .ROUND_EN(rnd), .TOS_IN(tos_w),
        .NOS_IN(nos_w), .PSTK_IN(pstk_w), .MEM_IN(16'h0004), .BUS_IN(16'h0100), .STK(stk), .INT_BLOCK(int_blk));
    core_stack_model core_stack_model_i (.clk(mclk), .rst(rst), .stk(stk), .ld(ld_s), .ld_val(ld_v),
        .tos_r(tos_w), .nos_r(nos_w), .pstk_r(pstk_w));

    // Compare and count
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Preset stack and rounding
    task automatic ld(input logic [47:0] v, input logic r);
        @(posedge mclk);
        ld_s <= 1'b1;
        ld_v <= v;
        rnd  <= r;
        @(posedge mclk);
        ld_s <= 1'b0;
    endtask : ld

    // One request cycle, then idle; ends where the effect is visible
    task automatic issue(input smu_pkg::op_t op, input smu_pkg::src_t src);
        @(posedge mclk);
        req <= '{op: op, src: src};
        @(posedge mclk);
        req <= '{op: smu_pkg::OP_NOP, src: smu_pkg::SRC_STACK};
        #1;
    endtask : issue

    // Result read with expected stack effect
    task automatic rd(input smu_pkg::op_t op, input logic [15:0] v);
        smu_pkg::stk_t e;
        e = '0;
        e.tos_we = 1'b1;
        e.nos_we = 1'b1;
        e.push = (op == smu_pkg::OP_RDEXT);
        e.tos = v;
        e.nos = tos_w;
        e.push_data = e.push ? nos_w : 16'h0;
        issue(op, smu_pkg::SRC_STACK);
        chk("read effect", stk, e);
        @(posedge mclk);
        #1;
    endtask : rd

    // Interrupt block over four cycles from the request
    task automatic blk(input smu_pkg::op_t op, input logic [3:0] pat);
        @(posedge mclk);
        req <= '{op: op, src: smu_pkg::SRC_STACK};
        for (int i = 0; i < 4; i++) begin
            #1;
            chk("interrupt block", int_blk, pat[i]);
            @(posedge mclk);
            req <= '{op: smu_pkg::OP_NOP, src: smu_pkg::SRC_STACK};
        end
    endtask : blk

    // Verdict and stop
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        smu_pkg::stk_t e;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("stack effect after reset", stk, 64'h0);
        foreach (rows[i]) begin
            ld({rows[i].t, rows[i].n, 16'h0010}, rows[i].rnd);
            issue(rows[i].op, rows[i].src);
            chk("no stack effect", stk, 64'h0);
            rd(smu_pkg::OP_RDLO, rows[i].l);
            rd(smu_pkg::OP_RDHI, rows[i].h);
            rd(smu_pkg::OP_RDEXT, rows[i].x);
        end
        $display("row table done");
        blk(smu_pkg::OP_MULU, 4'b0111);
        blk(smu_pkg::OP_RDLO, 4'b0011);
        blk(smu_pkg::OP_MACU, 4'b0000);
        $display("interrupt block done");
        ld(48'hFFFF_FFFF_0010, 1'b0);
        @(posedge mclk);
        req <= '{op: smu_pkg::OP_MULU, src: smu_pkg::SRC_STACK};
        rd(smu_pkg::OP_RDHI, 16'hFFFE);
        rd(smu_pkg::OP_RDLO, 16'h0001);
        $display("back to back done");
        foreach (lds[i]) begin
            ld(48'hABCD_1111_2222, 1'b0);
            e = '0;
            e.tos_we = 1'b1;
            e.nos_we = 1'b1;
            e.pop = 1'b1;
            e.tos = 16'h1111;
            e.nos = 16'h2222;
            issue(lds[i], smu_pkg::SRC_STACK);
            chk("load effect", stk, e);
            @(posedge mclk);
            #1;
            rd(rds[i], 16'hABCD);
        end
        $display("loads done");
        end_of_test();
    end

    // Watchdog well beyond the few hundred cycles expected
    initial begin
        #50000;
        failures++;
        end_of_test();
    end
endmodule : stack_math_unit_tb
